// *** inc/dlws_defines.svh ***
// Constants of the DLL switch and write-leveling sequencer.
// Assumes inclusion by bare name; plain definitions only.
`ifndef DLWS_DEFINES_SVH
`define DLWS_DEFINES_SVH
// Synchronised pin vector layout
`define DLWS_PIN_W 27
`define DLWS_P_CK 0
`define DLWS_P_CKE 1
`define DLWS_P_CS 2
`define DLWS_P_ACT 3
`define DLWS_P_OP 6:4
`define DLWS_P_BG0 7
`define DLWS_P_BA 10:9
`define DLWS_P_A 24:11
`define DLWS_P_DQS 26:25
// Opcodes on {we_n, cas_n, ras_n}
`define DLWS_OP_MRS 3'h0
`define DLWS_OP_WR 3'h1
`define DLWS_OP_ZQ 3'h3
`define DLWS_OP_REF 3'h4
`define DLWS_OP_RD 3'h5
// Mode register numbers and bits
`define DLWS_MR_AW 3
`define DLWS_MR_DW 14
`define DLWS_MR0 3'h0
`define DLWS_MR1 3'h1
`define DLWS_MR2 3'h2
`define DLWS_MR3 3'h3
`define DLWS_B_DLL 0
`define DLWS_B_PDA 4
`define DLWS_B_WL 7
`define DLWS_B_RST 8
// Register word indices (byte address = 4 x index)
`define DLWS_W_CTRL 6'h00
`define DLWS_W_TIM 6'h01
`define DLWS_W_STAT 6'h07
`define DLWS_W_MR 6'h08
`define DLWS_W_END 6'h10
`define DLWS_B_VIOL 8
// Timing slots, counts in CK cycles
`define DLWS_NTIM 6
`define DLWS_T_MOD 0
`define DLWS_T_MRD 1
`define DLWS_T_XSF 2
`define DLWS_T_XS 3
`define DLWS_T_XSA 4
`define DLWS_T_DLLK 5
`define DLWS_TMOD_RST 16'h0018
`define DLWS_TMRD_RST 16'h0008
`define DLWS_TXSF_RST 16'h0040
`define DLWS_TXS_RST 16'h0100
`define DLWS_TXSA_RST 16'h0080
`define DLWS_TDLLK_RST 16'h0400
`define DLWS_CNT_MAX 16'hffff
`define DLWS_LRN_DONE 2'h2
`endif

// *** inc/dlws_pkg.sv ***
// Types and helpers of the DLL switch and write-leveling sequencer.
// Assumes dlws_defines.svh is on the include path.
`include "dlws_defines.svh"
package dlws_pkg;
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_SREF = 3'h1,
        S_SRX  = 3'h2,
        S_WL   = 3'h3
    } dlws_state_t;

    typedef enum logic [2:0] {
        C_DES = 3'h0,
        C_MRS = 3'h1,
        C_REF = 3'h2,
        C_ZQ  = 3'h3,
        C_RD  = 3'h4,
        C_WR  = 3'h5,
        C_OTH = 3'h6
    } dlws_cmd_t;

    typedef struct packed {
        logic [`DLWS_PIN_W-1:0]             s1;
        logic [`DLWS_PIN_W-1:0]             s2;
        logic                               ck_q;
        logic                               cke_q;
        logic [1:0]                         dqs_q;
        dlws_state_t                        st;
        logic [15:0]                        ck_per;
        logic [15:0]                        ck_ref;
        logic [1:0]                         lrn;
        logic [15:0]                        xs_cnt;
        logic [15:0]                        mod_cnt;
        logic [15:0]                        mrd_cnt;
        logic [15:0]                        dllk_cnt;
        logic                               dll_en;
        logic                               dll_lock;
        logic                               pda;
        logic                               abort_en;
        logic                               need_ref;
        logic                               viol;
        logic [15:0]                        ref_cnt;
        logic [`DLWS_NTIM-1:0][15:0]        tim;
        logic                               pend;
        logic                               ack;
        logic [31:0]                        dat;
        logic [15:0]                        dq;
        logic [1:0]                         dq_oe_n;
        logic                               dqs_term;
    } dlws_st_t;

    typedef struct packed {
        logic [7:0][`DLWS_MR_DW-1:0]        m;
        logic [`DLWS_MR_DW-1:0]             rd;
    } dlws_mem_t;

    // Command decode from a synchronised pin vector
    function automatic dlws_cmd_t dlws_decode(input logic [`DLWS_PIN_W-1:0] p);
        dlws_cmd_t c;
        c = C_OTH;
        if (p[`DLWS_P_CS]) begin
            c = C_DES;
        end else if (p[`DLWS_P_ACT]) begin
            case (p[`DLWS_P_OP])
                `DLWS_OP_MRS: c = C_MRS;
                `DLWS_OP_REF: c = C_REF;
                `DLWS_OP_ZQ:  c = C_ZQ;
                `DLWS_OP_RD:  c = C_RD;
                `DLWS_OP_WR:  c = C_WR;
                default:      c = C_OTH;
            endcase
        end
        return c;
    endfunction

    // Saturating counter step
    function automatic logic [15:0] dlws_inc(input logic [15:0] v);
        return (v == `DLWS_CNT_MAX) ? v : v + 16'h1;
    endfunction

    // Byte-enable merge of a 16-bit register
    function automatic logic [15:0] dlws_merge(input logic [15:0] o, input logic [15:0] d,
                                               input logic [1:0] sel);
        return {sel[1] ? d[15:8] : o[15:8], sel[0] ? d[7:0] : o[7:0]};
    endfunction
endpackage

// *** inc/dlws_mr_if.sv ***
// Mode register shadow port between sequencer and its store.
// Assumes one writer (sequencer) and one reader port.
`timescale 1ns/1ps
`include "dlws_defines.svh"
interface dlws_mr_if;
    logic                   we;
    logic [`DLWS_MR_AW-1:0] waddr;
    logic [`DLWS_MR_DW-1:0] wdata;
    logic [`DLWS_MR_AW-1:0] raddr;
    logic [`DLWS_MR_DW-1:0] rdata;
    modport ctrl (output we, waddr, wdata, raddr, input rdata);
    modport mem  (input we, waddr, wdata, raddr, output rdata);
endinterface

// *** core/dlws_mr_mem.sv ***
// Mode register shadow store, eight words, registered read.
// Assumes writes and reads on clk_i; read data one cycle late.
`timescale 1ns/1ps
`include "dlws_defines.svh"
module dlws_mr_mem
    import dlws_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    dlws_mr_if.mem    mr
);
    dlws_mem_t s, next_s;

    // Write port and registered read port
    always_comb begin
        next_s = s;
        if (mr.we) begin
            next_s.m[mr.waddr] = mr.wdata;
        end
        next_s.rd = s.m[mr.raddr];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign mr.rdata = s.rd;
endmodule

// *** core/dlws_top.sv ***
// DDR4 device-side DLL on/off, self refresh exit and write-leveling sequencer.
// Assumes CK and command pins are asynchronous; registers over classic Wishbone.
// Notes on behaviour
// R01 - Host idles device before DLL-off write
// R02 - MR1 A0 write switches DLL; tMOD before SR
// R03 - Clock may change after tCKSRE in SR
// R04 - Clock stays stable outside self refresh
// R05 - Host holds CKE high through tMOD
// R06 - Host waits tXS before normal commands
// R07 - After tXS_FAST only ZQ, limited MRS
// R08 - Abort skips refresh count, uses tXS_ABORT
// R09 - One refresh needed before next SR
// R10 - Device takes commands after tMOD
// R11 - Host DLL-on sequence through self refresh
// R12 - Host holds CKE high until tDLLK
// R13 - DLL enable write, tMRD, then reset
// R14 - DLL reset by explicit MR bit 8
// R15 - Host waits tDLLK before DLL commands
// R16 - Honour programmable DLL lock time
// R17 - Host keeps frequency within grade range
// R18 - Strobe rise samples CK onto DQ
// R19 - Host steps strobe delay until 0-to-1
// R20 - Each byte lane reports its own strobe
// R21 - Device terminates strobes while leveling
// R22 - Host sends deselect during exit period
// R23 - MR1 A7 enters and leaves leveling
// R24 - DLL polarity and reset bit parameters
// R25 - Early commands after exit flagged
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "dlws_defines.svh"
module dlws_top
    import dlws_pkg::*;
#(
    parameter logic        DLL_OFF_VAL = 1'h1,
    parameter logic [2:0]  DLL_RST_MR  = `DLWS_MR0,
    parameter logic [15:0] CK_TOL      = 16'h0001
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        ck_i,
    input  wire logic        cke_i,
    input  wire logic        cs_n_i,
    input  wire logic        act_n_i,
    input  wire logic        ras_n_i,
    input  wire logic        cas_n_i,
    input  wire logic        we_n_i,
    input  wire logic [1:0]  bg_i,
    input  wire logic [1:0]  ba_i,
    input  wire logic [13:0] addr_i,
    input  wire logic [1:0]  dqs_i,
    output logic      [15:0] dq_o,
    output logic      [1:0]  dq_oe_n_o,
    output logic             dqs_term_o,
    output logic             dll_lock_o
);
    logic [`DLWS_PIN_W-1:0] pins;
    dlws_st_t               s, next_s;
    dlws_cmd_t              cmd;
    logic                   ck_s, cke_s, ck_rise, take, sre, srx;
    logic                   mod_ok, mrd_ok, fast_mr, bus_go;
    logic [1:0]             dqs_rise;
    logic [2:0]             mrn;
    logic [13:0]            a;
    logic [15:0]            xs_lim, ck_dev;
    logic [5:0]             wa, tw;
    logic [2:0]             tix;
    logic                   is_tim, is_mr;
    dlws_mr_if              mr_bus ();

    dlws_mr_mem u_mem (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .mr    (mr_bus)
    );

    // All pins pass the two-stage synchroniser in s1/s2
    assign pins = {dqs_i, addr_i, ba_i, bg_i, we_n_i, cas_n_i, ras_n_i, act_n_i, cs_n_i, cke_i, ck_i};

    // Decode of the synchronised pin state
    assign ck_s     = s.s2[`DLWS_P_CK];
    assign cke_s    = s.s2[`DLWS_P_CKE];
    assign ck_rise  = ck_s & ~s.ck_q;
    assign dqs_rise = s.s2[`DLWS_P_DQS] & ~s.dqs_q;
    assign cmd      = dlws_decode(s.s2);
    assign mrn      = {s.s2[`DLWS_P_BG0], s.s2[`DLWS_P_BA]};
    assign a        = s.s2[`DLWS_P_A];
    assign take     = ck_rise & cke_s & (s.st != S_SREF) & (cmd != C_DES);
    assign sre      = ck_rise & s.cke_q & ~cke_s & (cmd == C_REF) & (s.st == S_IDLE);
    assign srx      = ck_rise & ~s.cke_q & cke_s & (s.st == S_SREF);
    assign mod_ok   = s.mod_cnt >= s.tim[`DLWS_T_MOD];
    assign mrd_ok   = s.mrd_cnt >= s.tim[`DLWS_T_MRD];
    assign xs_lim   = s.abort_en ? s.tim[`DLWS_T_XSA] : s.tim[`DLWS_T_XS]; // see R08
    assign ck_dev   = (s.ck_per > s.ck_ref) ? s.ck_per - s.ck_ref : s.ck_ref - s.ck_per;
    // Writes allowed early: CL/WR in MR0, CWL in MR2, geardown in MR3
    assign fast_mr  = (mrn == `DLWS_MR0 || mrn == `DLWS_MR2 || mrn == `DLWS_MR3) & ~s.pda; // see R07

    // Bus address decode, one word per register
    assign wa     = wb_adr_i[7:2];
    assign tw     = wa - `DLWS_W_TIM;
    assign tix    = tw[2:0];
    assign is_tim = (wa >= `DLWS_W_TIM) && (wa < `DLWS_W_STAT);
    assign is_mr  = (wa >= `DLWS_W_MR) && (wa < `DLWS_W_END);
    assign bus_go = wb_cyc_i & wb_stb_i & ~s.ack & s.pend;

    // Mode register shadow writes come straight from decoded MRS
    assign mr_bus.we    = take & (cmd == C_MRS);
    assign mr_bus.waddr = mrn;
    assign mr_bus.wdata = a;
    assign mr_bus.raddr = wa[2:0];

    // Next-state logic of the whole block
    always_comb begin
        next_s       = s;
        next_s.s1    = pins;
        next_s.s2    = s.s1;
        next_s.ck_q  = ck_s;
        next_s.dqs_q = s.s2[`DLWS_P_DQS];
        next_s.ck_per = dlws_inc(s.ck_per);
        next_s.dll_lock = s.dll_en & (s.dllk_cnt >= s.tim[`DLWS_T_DLLK]); // see R16
        next_s.dq_oe_n  = (s.st == S_WL) ? 2'h0 : 2'h3;
        next_s.dqs_term = (s.st == S_WL); // see R21

        // Bus first, so that a hardware flag set below wins over a clear
        next_s.ack = 1'h0;
        next_s.pend = wb_cyc_i & wb_stb_i & ~s.ack & ~s.pend;
        if (bus_go) begin
            next_s.ack = 1'h1;
            next_s.dat = 32'h0;
            if (wa == `DLWS_W_CTRL) begin
                next_s.dat = {31'h0, s.abort_en};
            end else if (is_tim) begin
                next_s.dat = {16'h0, s.tim[tix]};
            end else if (wa == `DLWS_W_STAT) begin
                next_s.dat = {s.ref_cnt, 7'h0, s.viol, s.pda, s.need_ref, 1'h0,
                              s.dll_lock, s.dll_en, s.st};
            end else if (is_mr) begin
                next_s.dat = {18'h0, mr_bus.rdata};
            end
            if (wb_we_i) begin
                if (wa == `DLWS_W_CTRL && wb_sel_i[0]) begin
                    next_s.abort_en = wb_dat_i[0];
                end else if (is_tim) begin
                    next_s.tim[tix] = dlws_merge(s.tim[tix], wb_dat_i[15:0], wb_sel_i[1:0]);
                end else if (wa == `DLWS_W_STAT && wb_sel_i[1] && wb_dat_i[`DLWS_B_VIOL]) begin
                    next_s.viol = 1'h0;
                end
            end
        end

        // CK edge bookkeeping: counters in CK cycles, period watch
        if (ck_rise) begin
            next_s.cke_q    = cke_s;
            next_s.ck_per   = 16'h1;
            next_s.xs_cnt   = dlws_inc(s.xs_cnt);
            next_s.mod_cnt  = dlws_inc(s.mod_cnt);
            next_s.mrd_cnt  = dlws_inc(s.mrd_cnt);
            next_s.dllk_cnt = dlws_inc(s.dllk_cnt);
            if (s.st == S_SREF) begin
                next_s.lrn = 2'h0; // clock is free to change here
            end else if (s.lrn != `DLWS_LRN_DONE) begin
                next_s.lrn    = s.lrn + 2'h1;
                next_s.ck_ref = s.ck_per;
            end else if (ck_dev > CK_TOL) begin
                next_s.viol = 1'h1; // period moved outside self refresh
            end
        end

        // Self refresh entry, exit wait and return to idle
        unique case (s.st)
            S_IDLE: begin
                if (sre) begin
                    next_s.st = S_SREF;
                    if (s.need_ref || !mod_ok) begin
                        next_s.viol = 1'h1; // see R02 see R25
                    end
                end else if (take && cmd == C_REF) begin
                    next_s.ref_cnt  = s.ref_cnt + 16'h1;
                    next_s.need_ref = 1'h0;
                end
            end
            S_SREF: begin
                if (srx) begin
                    next_s.st       = S_SRX;
                    next_s.xs_cnt   = 16'h0;
                    next_s.need_ref = 1'h1;
                    // Abort drops the refresh in flight uncounted
                    if (!s.abort_en) begin
                        next_s.ref_cnt = s.ref_cnt + 16'h1; // see R08
                    end
                end
            end
            S_SRX: begin
                if (s.xs_cnt >= xs_lim) begin
                    next_s.st = S_IDLE; // see R08
                end
            end
            S_WL: begin
                next_s.st = S_WL;
            end
            default: begin
                next_s.st = S_IDLE;
            end
        endcase

        // Command legality per state
        if (take) begin
            if (s.st == S_SRX) begin
                if (s.xs_cnt < s.tim[`DLWS_T_XSF] || !(cmd == C_ZQ || (cmd == C_MRS && fast_mr))) begin
                    next_s.viol = 1'h1; // see R07 see R25
                end
            end else if (s.st == S_WL) begin
                if (cmd != C_MRS) begin
                    next_s.viol = 1'h1;
                end
            end else begin
                if (cmd != C_MRS && !mod_ok) begin
                    next_s.viol = 1'h1; // see R10
                end
                if (cmd == C_MRS && !mrd_ok) begin
                    next_s.viol = 1'h1; // see R13
                end
                if ((cmd == C_RD || cmd == C_WR) && s.dll_en && !s.dll_lock) begin
                    next_s.viol = 1'h1; // see R16
                end
            end
        end

        // Effects of a mode register write
        if (take && cmd == C_MRS) begin
            next_s.mod_cnt = 16'h0; // see R10
            next_s.mrd_cnt = 16'h0; // see R13
            if (mrn == `DLWS_MR1) begin
                next_s.dll_en = (a[`DLWS_B_DLL] != DLL_OFF_VAL); // see R02 see R24
                if (a[`DLWS_B_WL] && s.st == S_IDLE) begin
                    next_s.st = S_WL; // see R23
                end else if (!a[`DLWS_B_WL] && s.st == S_WL) begin
                    next_s.st = S_IDLE; // see R23
                end
            end
            // Reset bit location chosen at build time
            if (mrn == DLL_RST_MR && a[`DLWS_B_RST]) begin
                next_s.dllk_cnt = 16'h0; // see R14 see R24
            end
            if (mrn == `DLWS_MR3) begin
                next_s.pda = a[`DLWS_B_PDA];
            end
        end

        // Leveling feedback: each lane samples CK on its own strobe
        for (int l = 0; l < 2; l++) begin
            if (s.st == S_WL && dqs_rise[l]) begin
                next_s.dq[l*8 +: 8] = {8{ck_s}}; // see R18 see R20
            end
        end
    end

    // State register; DLL starts enabled, locked one cycle after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.tim[`DLWS_T_MOD]  <= `DLWS_TMOD_RST;
            s.tim[`DLWS_T_MRD]  <= `DLWS_TMRD_RST;
            s.tim[`DLWS_T_XSF]  <= `DLWS_TXSF_RST;
            s.tim[`DLWS_T_XS]   <= `DLWS_TXS_RST;
            s.tim[`DLWS_T_XSA]  <= `DLWS_TXSA_RST;
            s.tim[`DLWS_T_DLLK] <= `DLWS_TDLLK_RST; // see R16
            s.mod_cnt  <= `DLWS_CNT_MAX;
            s.mrd_cnt  <= `DLWS_CNT_MAX;
            s.dllk_cnt <= `DLWS_CNT_MAX;
            s.dll_en   <= 1'h1;
            s.cke_q    <= 1'h1;
            s.dq_oe_n  <= 2'h3;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign wb_dat_o   = s.dat;
    assign wb_ack_o   = s.ack;
    assign dq_o       = s.dq;
    assign dq_oe_n_o  = s.dq_oe_n;
    assign dqs_term_o = s.dqs_term;
    assign dll_lock_o = s.dll_lock;

    // Checks on the sequencing above
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_fast_cmd_flag: assert property (take && s.st == S_SRX && s.xs_cnt < s.tim[`DLWS_T_XSF] |=> s.viol) // see R07
        else $error("early command after exit not flagged");
    a_abort_keep_cnt: assert property (srx && s.abort_en |=> s.ref_cnt == $past(s.ref_cnt)) // see R08
        else $error("aborted refresh was counted");
    a_srx_refresh_cnt: assert property (srx && !s.abort_en |=> s.ref_cnt == $past(s.ref_cnt) + 16'h1) // see R08
        else $error("exit refresh not counted");
    a_mod_early_flag: assert property (take && s.st == S_IDLE && cmd != C_MRS && !mod_ok |=> s.viol) // see R10
        else $error("command inside tMOD not flagged");
    a_mrd_early_flag: assert property (take && s.st == S_IDLE && cmd == C_MRS && !mrd_ok |=> s.viol) // see R13
        else $error("MRS inside tMRD not flagged");
    a_dll_reset_start: assert property (take && cmd == C_MRS && mrn == DLL_RST_MR && a[`DLWS_B_RST] // see R14
        |=> s.dllk_cnt == 16'h0 ##1 !s.dll_lock)
        else $error("DLL reset did not restart lock");
    a_lock_time_held: assert property (s.dll_en && s.dllk_cnt < s.tim[`DLWS_T_DLLK] |=> !dll_lock_o) // see R16
        else $error("lock shown before tDLLK");
    a_dll_polarity: assert property (take && cmd == C_MRS && mrn == `DLWS_MR1 // see R24
        |=> s.dll_en == ($past(a[`DLWS_B_DLL]) != DLL_OFF_VAL))
        else $error("DLL enable polarity wrong");
    a_wl_lower_fb: assert property (s.st == S_WL && dqs_rise[0] |=> dq_o[7:0] == {8{$past(ck_s)}}) // see R18
        else $error("lower lane feedback wrong");
    a_wl_upper_fb: assert property (s.st == S_WL && dqs_rise[1] |=> dq_o[15:8] == {8{$past(ck_s)}}) // see R20
        else $error("upper lane feedback wrong");
    a_wl_entry: assert property (take && cmd == C_MRS && mrn == `DLWS_MR1 && a[`DLWS_B_WL] // see R23
        && s.st == S_IDLE |=> s.st == S_WL ##1 (dqs_term_o && dq_oe_n_o == 2'h0))
        else $error("leveling entry failed");
    a_wl_term_on: assert property (s.st == S_WL [*2] |-> dqs_term_o && dq_oe_n_o == 2'h0) // see R21
        else $error("strobe termination off in leveling");
    a_sre_no_refresh: assert property (sre && s.need_ref |=> s.viol) // see R25
        else $error("re-entry without refresh not flagged");

    c_self_refresh_exit: cover property (srx);
    c_exit_to_idle: cover property (s.st == S_SRX ##1 s.st == S_IDLE);
    c_wl_feedback_one: cover property (s.st == S_WL && dqs_rise[0] && ck_s);
    c_dll_reset: cover property (take && cmd == C_MRS && mrn == DLL_RST_MR && a[`DLWS_B_RST]);
endmodule

// *** verif/dlws_ctl.sv ***
// Behavioural controller driving CK, command pins and strobes.
// Assumes the bench calls one task at a time; CK runs free.
`timescale 1ns/1ps
module dlws_ctl (
    input  wire logic   clk_i,
    output logic        ck_o,
    output logic        cke_o,
    output logic        cs_n_o,
    output logic        act_n_o,
    output logic [2:0]  op_o,
    output logic [1:0]  bg_o,
    output logic [1:0]  ba_o,
    output logic [13:0] addr_o,
    output logic [1:0]  dqs_o
);
    realtime half = 24.0;
    initial {ck_o, cke_o, cs_n_o, act_n_o, op_o, bg_o, ba_o, addr_o, dqs_o} = {4'h7, 3'h7, 18'h0, 2'h0};
    // Period only altered by set_half, which is called inside self refresh
    always #(half) ck_o = ~ck_o;
    // One command on a CK rise, deselect afterwards
    task automatic cmd(input logic [2:0] op, input logic [2:0] mr, input logic [13:0] a, input logic ke);
        @(negedge ck_o);
        cs_n_o <= 1'b0;
        cke_o  <= ke; // Low with refresh enters self refresh
        op_o   <= op;
        bg_o   <= {1'b0, mr[2]};
        ba_o   <= mr[1:0];
        addr_o <= a;
        @(negedge ck_o);
        cs_n_o <= 1'b1;
        addr_o <= ~a; // Released bus must not look held
    endtask
    // CKE then stays high through the exit timings
    task automatic srx();
        @(negedge ck_o);
        cke_o <= 1'b1;
    endtask
    task automatic ckw(input int n);
        repeat (n) @(posedge ck_o);
    endtask
    // New rate only while in self refresh
    task automatic set_half(input realtime h);
        half = h;
    endtask
    // One strobe pulse in the high or low CK phase
    task automatic strobe(input int lane, input logic hi);
        if (hi) @(posedge ck_o);
        else @(negedge ck_o);
        repeat (2) @(posedge clk_i);
        dqs_o[lane] <= 1'b1;
        repeat (4) @(posedge clk_i);
        dqs_o[lane] <= 1'b0;
    endtask
endmodule

// *** verif/dlws_top_test.sv ***
// Self-checking bench: registers, self refresh exits, DLL switching, leveling.
// Assumes dlws_ctl drives the pins; timings shortened through registers.
`timescale 1ns/1ps
`include "dlws_defines.svh"
module dlws_top_test;
    localparam logic [2:0] MRS = `DLWS_OP_MRS;
    localparam logic [2:0] REF = `DLWS_OP_REF;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        we    = 1'b0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] wdat  = 32'h0;
    logic [3:0]  sel   = 4'hf;
    logic [31:0] rdat, c0, wb_dat;
    logic        wb_ack, ck, cke, cs_n, act_n, term, lock;
    logic [2:0]  op;
    logic [1:0]  bg, ba, dqs, oe_n;
    logic [13:0] a;
    logic [15:0] dq;
    int          fails = 0;
    int          checks = 0;
    int          cycles = 0;
    always #2.5 clk_i = ~clk_i;
    dlws_top u_dlws_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .ck_i(ck),
        .cke_i(cke), .cs_n_i(cs_n), .act_n_i(act_n), .ras_n_i(op[0]), .cas_n_i(op[1]), .we_n_i(op[2]),
        .bg_i(bg), .ba_i(ba), .addr_i(a), .dqs_i(dqs), .dq_o(dq), .dq_oe_n_o(oe_n), .dqs_term_o(term),
        .dll_lock_o(lock));
    dlws_ctl u_dlws_ctl (.clk_i(clk_i), .ck_o(ck), .cke_o(cke), .cs_n_o(cs_n), .act_n_o(act_n), .op_o(op),
        .bg_o(bg), .ba_o(ba), .addr_o(a), .dqs_o(dqs));
    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_pin(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Classic cycle; request held to the edge that samples ack high
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        cyc  <= 1'b1;
        we   <= w;
        adr  <= ad;
        wdat <= d;
        do @(posedge clk_i); while (wb_ack !== 1'b1);
        rdat = wb_dat;
        cyc <= 1'b0;
    endtask
    task automatic stat(input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, 8'h1c, 32'h0);
        chk_reg(rdat & m, e);
    endtask
    task automatic settle();
        repeat (6) @(negedge clk_i);
    endtask
    task automatic sre();
        u_dlws_ctl.cmd(REF, 3'h0, 14'h0, 1'b1);
        wb(1'b0, 8'h1c, 32'h0);
        c0 = rdat;
        u_dlws_ctl.cmd(REF, 3'h0, 14'h0, 1'b0);
        u_dlws_ctl.ckw(2);
    endtask
    task automatic t_regs();
        stat(32'h11f, 32'h18);
        wb(1'b0, 8'h04, 32'h0);
        chk_reg(rdat, 32'h18);
        wb(1'b1, 8'h40, 32'hffff);
        wb(1'b0, 8'h40, 32'h0);
        chk_reg(rdat, 32'h0);
        sel <= 4'h1;
        wb(1'b1, 8'h0c, 32'hff08);
        sel <= 4'hf;
        wb(1'b1, 8'h10, 32'h10);
        wb(1'b1, 8'h14, 32'hc);
        wb(1'b1, 8'h18, 32'h20);
        wb(1'b0, 8'h18, 32'h0);
        chk_reg(rdat, 32'h20);
    endtask
    task automatic t_dll_off();
        u_dlws_ctl.cmd(MRS, `DLWS_MR1, 14'h0001, 1'b1);
        u_dlws_ctl.ckw(25);
        settle();
        chk_pin({15'h0, lock}, 16'h0);
        sre();
        u_dlws_ctl.set_half(30.0);
        settle();
        stat(32'h7, 32'h1);
        u_dlws_ctl.ckw(4);
        u_dlws_ctl.srx();
        u_dlws_ctl.ckw(3);
        settle();
        stat(32'h7, 32'h2);
        u_dlws_ctl.ckw(16);
        settle();
        stat(32'hffff01df, {c0[31:16] + 16'h1, 16'h0040});
    endtask
    // Legal limited write after the short exit, then two offences
    task automatic t_early();
        sre();
        u_dlws_ctl.srx();
        u_dlws_ctl.ckw(9);
        u_dlws_ctl.cmd(MRS, `DLWS_MR2, 14'h0, 1'b1);
        settle();
        stat(32'h100, 32'h0);
        u_dlws_ctl.ckw(25);
        u_dlws_ctl.cmd(REF, 3'h0, 14'h0, 1'b0);
        settle();
        stat(32'h100, 32'h100);
        wb(1'b1, 8'h1c, 32'h100);
        stat(32'h100, 32'h0);
        u_dlws_ctl.srx();
        u_dlws_ctl.ckw(2);
        u_dlws_ctl.cmd(`DLWS_OP_ZQ, 3'h0, 14'h0, 1'b1);
        settle();
        stat(32'h100, 32'h100);
        wb(1'b1, 8'h1c, 32'h100);
        u_dlws_ctl.ckw(20);
    endtask
    task automatic t_dll_on();
        wb(1'b1, 8'h00, 32'h1);
        sre();
        u_dlws_ctl.set_half(24.0);
        u_dlws_ctl.ckw(4);
        u_dlws_ctl.srx();
        u_dlws_ctl.ckw(14);
        settle();
        stat(32'hffff0107, {c0[31:16], 16'h0});
        u_dlws_ctl.cmd(MRS, `DLWS_MR1, 14'h0000, 1'b1);
        u_dlws_ctl.ckw(9);
        u_dlws_ctl.cmd(MRS, `DLWS_MR0, 14'h0100, 1'b1);
        u_dlws_ctl.ckw(3);
        settle();
        chk_pin({15'h0, lock}, 16'h0);
        u_dlws_ctl.ckw(34);
        settle();
        chk_pin({15'h0, lock}, 16'h1);
        stat(32'h11f, 32'h18);
    endtask
    task automatic t_level();
        u_dlws_ctl.ckw(25);
        u_dlws_ctl.cmd(MRS, `DLWS_MR1, 14'h0080, 1'b1);
        u_dlws_ctl.ckw(2);
        settle();
        chk_pin({13'h0, term, oe_n}, 16'h4);
        u_dlws_ctl.strobe(0, 1'b1);
        settle();
        chk_pin(dq, 16'h00ff);
        u_dlws_ctl.strobe(1, 1'b0);
        settle();
        chk_pin(dq, 16'h00ff);
        u_dlws_ctl.strobe(1, 1'b1);
        settle();
        chk_pin(dq, 16'hffff);
        u_dlws_ctl.cmd(MRS, `DLWS_MR1, 14'h0, 1'b1);
        u_dlws_ctl.ckw(2);
        settle();
        chk_pin({13'h0, term, oe_n}, 16'h3);
    endtask
    // Ceiling far above the few thousand cycles the tests need
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        $display("test regs done");
        t_dll_off();
        $display("test dll off done");
        t_early();
        $display("test early done");
        t_dll_on();
        $display("test dll on done");
        t_level();
        $display("test level done");
        give_verdict();
    end
endmodule
